// File: core/wd_pkg.sv
// constants, field layouts and carrier types of the watchdog control block
// assumes a byte-wide register port and counting ticks synchronous to clk_i
package wd_pkg;

	// register offsets on the byte-wide port
	localparam logic [7:0] ADDR_CONTROL = 8'h0C;
	localparam logic [7:0] ADDR_SERVICE = 8'h0F;
	localparam logic [7:0] ADDR_CLKSEL = 8'h20;
	localparam logic [7:0] ADDR_STATUS = 8'h21;

	// control register field positions
	localparam int CTL_WINDOW_BIT = 7;
	localparam int CTL_HALT_BIT = 6;
	localparam int CTL_MASK_BIT = 5;
	localparam int CTL_RATE_MSB = 2;

	// clock select register field positions
	localparam int CLK_OSC_BIT = 0;
	localparam int CLK_AUTO_BIT = 1;

	// service register values
	localparam logic [7:0] SERVICE_FIRST = 8'h55;
	localparam logic [7:0] SERVICE_SECOND = 8'hAA;

	localparam logic [2:0] RATE_OFF = 3'h0;
	localparam logic [4:0] DEBUG_LONG_SHIFT = 5'h18;
	localparam int CNT_W = 25;

	typedef struct packed {
		logic window_mode;
		logic halt_in_debug;
		logic [2:0] timeout_rate;
	} wd_ctrl_t;

	typedef struct packed {
		logic wd_autonomous_select;
		logic wd_osc_select;
	} wd_clksel_t;

	typedef enum logic [1:0] {
		SVC_IDLE = 2'b00,
		SVC_ARMED = 2'b01
	} svc_state_t;

	// log2 of the time-out in counting-clock cycles
	function automatic logic [4:0] rate_shift(input logic autonomous, input logic [2:0] rate);
		logic [4:0] s;
		s = 5'h0;
		if (autonomous) begin
			case (rate)
				3'h1: s = 5'h07;
				3'h2: s = 5'h09;
				3'h3: s = 5'h0B;
				3'h4: s = 5'h0D;
				3'h5: s = 5'h0F;
				3'h6: s = 5'h10;
				3'h7: s = 5'h11;
				default: s = 5'h0;
			endcase
		end else begin
			case (rate)
				3'h1: s = 5'h0E;
				3'h2: s = 5'h10;
				3'h3: s = 5'h12;
				3'h4: s = 5'h14;
				3'h5: s = 5'h16;
				3'h6: s = 5'h17;
				3'h7: s = 5'h18;
				default: s = 5'h0;
			endcase
		end
		return s;
	endfunction

endpackage

// File: core/wd_control.sv
// watchdog control: control register, clock choice, service sequence, time-out counter
// assumes all inputs synchronous to clk_i; count ticks are one-cycle enables
//
// Behaviour
// - counter ticks from autonomous, RC or crystal
// - pseudo stop with crystal and run keeps counting
// - autonomous select keeps counting in all stops
// - control register loaded from flash after reset
// - halt bit free in special, set-only normal
// - window and rate write-once normal, masked ignored
// - zero rate or clear window consume once
// - nonzero flash rate starts the time-out
// - clock select change or crystal loss restarts
// - normal effective write or halt set restarts
// - special mode: every control write restarts
// - window mode: early service write resets
// - repeated first value, second value restarts
// - halt bit stops counters in background debug
// - write mask protects window, rate, once
// - rate selects time-out; expiry asserts reset
// - special debug without halt uses longest period
// - bit seven selects windowed operation
// - standard rate table, code zero disables
// - autonomous clock halved, short rate table
// - first then second value services; others reset
// - rate zero: service ignored, reads zero
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ns
module wd_control
	import wd_pkg::*;
#(
	parameter int RATE_SHIFT_REDUCE = 0
) (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	// register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	output logic [7:0] rd_data_o,
	// counting ticks
	input wire logic aclk_tick_i,
	input wire logic internal_rc_clock_i,
	input wire logic crystal_clock_i,
	// chip mode and status
	input wire wd_ctrl_t flash_ctrl_i,
	input wire logic special_mode_i,
	input wire logic stop_mode_i,
	input wire logic pseudo_stop_select_i,
	input wire logic osc_run_in_pseudo_stop_i,
	input wire logic osc_ok_flag_i,
	input wire logic background_debug_i,
	// results
	output logic wd_reset_o,
	output logic periodic_tick_halt_o
);

	wd_ctrl_t ctrl;
	wd_clksel_t clksel;
	svc_state_t svc_state;
	logic load_pending;
	logic once_used;
	logic aclk_half;
	logic osc_ok_q;
	logic [CNT_W-1:0] cnt;

	logic ctl_wr, svc_wr, clk_wr;
	logic fields_ok;
	logic enabled, debug_long, window_eff;
	logic stop_halt, debug_halt, run, tick;
	logic [4:0] eff_shift;
	logic [CNT_W-1:0] limit, win_start;
	logic expire, bad_value, early_write, service_done;
	logic restart;

	assign ctl_wr = ce_i && wr_en_i && addr_i == ADDR_CONTROL;
	assign svc_wr = ce_i && wr_en_i && addr_i == ADDR_SERVICE;
	assign clk_wr = ce_i && wr_en_i && addr_i == ADDR_CLKSEL;
	// window and rate may change on this write
	assign fields_ok = !wr_data_i[CTL_MASK_BIT] && (special_mode_i || !once_used);

	assign enabled = ctrl.timeout_rate != RATE_OFF && !load_pending;
	assign debug_long = enabled && background_debug_i && !ctrl.halt_in_debug
		&& special_mode_i;
	assign window_eff = ctrl.window_mode && !debug_long;

	// period selection
	always_comb begin
		logic [4:0] s;
		s = debug_long ? DEBUG_LONG_SHIFT
			: rate_shift(clksel.wd_autonomous_select, ctrl.timeout_rate);
		eff_shift = s - 5'(RATE_SHIFT_REDUCE);
	end
	assign limit = (CNT_W'(1) << eff_shift) - CNT_W'(1);
	// first 75 percent ends at three quarters of the period
	assign win_start = CNT_W'(3) << (eff_shift - 5'h2);

	// keeping running in stop needs a clock that stays alive there
	always_comb begin
		if (!stop_mode_i || clksel.wd_autonomous_select) begin
			stop_halt = 1'b0;
		end else begin
			stop_halt = !(pseudo_stop_select_i && clksel.wd_osc_select
				&& osc_run_in_pseudo_stop_i);
		end
	end
	assign debug_halt = background_debug_i && ctrl.halt_in_debug;
	assign run = enabled && !stop_halt && !debug_halt;

	// counting tick source
	always_comb begin
		if (clksel.wd_autonomous_select) begin
			tick = aclk_tick_i && aclk_half;
		end else if (clksel.wd_osc_select) begin
			tick = crystal_clock_i;
		end else begin
			tick = internal_rc_clock_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			aclk_half <= 1'b0;
		end else if (ce_i && aclk_tick_i) begin
			aclk_half <= !aclk_half;
		end
	end

	// service sequence checks
	assign bad_value = svc_wr && enabled && wr_data_i != SERVICE_FIRST
		&& wr_data_i != SERVICE_SECOND;
	assign early_write = svc_wr && enabled && window_eff && cnt < win_start;
	assign service_done = svc_wr && enabled && !early_write && svc_state == SVC_ARMED
		&& wr_data_i == SERVICE_SECOND;
	assign expire = ce_i && run && tick && cnt >= limit;

	// restart sources
	always_comb begin
		restart = service_done;
		if (clk_wr && wr_data_i[1:0] != clksel) begin
			restart = 1'b1;
		end
		if (ce_i && osc_ok_q && !osc_ok_flag_i && !clksel.wd_autonomous_select
			&& clksel.wd_osc_select) begin
			restart = 1'b1;
		end
		if (ctl_wr && special_mode_i && !load_pending) begin
			restart = 1'b1;
		end
		if (ctl_wr && !special_mode_i && !load_pending) begin
			if (fields_ok && (wr_data_i[CTL_RATE_MSB:0] != RATE_OFF
				|| wr_data_i[CTL_WINDOW_BIT])) begin
				restart = 1'b1;
			end
			if (!ctrl.halt_in_debug && wr_data_i[CTL_HALT_BIT]) begin
				restart = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			osc_ok_q <= 1'b0;
		end else if (ce_i) begin
			osc_ok_q <= osc_ok_flag_i;
		end
	end

	// control register and flash load
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ctrl <= '0;
			load_pending <= 1'b1;
			once_used <= 1'b0;
		end else if (ce_i && load_pending) begin
			// counter is cleared by reset, so a nonzero rate starts from zero here
			ctrl <= flash_ctrl_i;
			load_pending <= 1'b0;
		end else if (ctl_wr) begin
			if (special_mode_i) begin
				ctrl.halt_in_debug <= wr_data_i[CTL_HALT_BIT];
			end else if (wr_data_i[CTL_HALT_BIT]) begin
				ctrl.halt_in_debug <= 1'b1;
			end
			if (fields_ok) begin
				if (special_mode_i) begin
					ctrl.window_mode <= wr_data_i[CTL_WINDOW_BIT];
					ctrl.timeout_rate <= wr_data_i[CTL_RATE_MSB:0];
				end else begin
					once_used <= 1'b1;
					if (wr_data_i[CTL_WINDOW_BIT]) begin
						ctrl.window_mode <= 1'b1;
					end
					if (wr_data_i[CTL_RATE_MSB:0] != RATE_OFF) begin
						ctrl.timeout_rate <= wr_data_i[CTL_RATE_MSB:0];
					end
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			clksel <= '0;
		end else if (clk_wr) begin
			clksel <= wr_data_i[1:0];
		end
	end

	// service state: the first value may repeat; only the second one completes
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			svc_state <= SVC_IDLE;
		end else if (ce_i) begin
			case (svc_state)
				SVC_IDLE: begin
					if (svc_wr && enabled && wr_data_i == SERVICE_FIRST) begin
						svc_state <= SVC_ARMED;
					end
				end
				SVC_ARMED: begin
					if (restart || !enabled) begin
						svc_state <= SVC_IDLE;
					end
				end
				default: svc_state <= SVC_IDLE;
			endcase
		end
	end

	// time-out counter
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cnt <= '0;
		end else if (ce_i) begin
			if (restart || !enabled || expire) begin
				cnt <= '0;
			end else if (run && tick) begin
				cnt <= cnt + CNT_W'(1);
			end
		end
	end

	// reset request: a single pulse, the system reset is expected to follow
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wd_reset_o <= 1'b0;
		end else if (ce_i) begin
			wd_reset_o <= expire || bad_value || early_write;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			periodic_tick_halt_o <= 1'b0;
		end else if (ce_i) begin
			periodic_tick_halt_o <= debug_halt;
		end
	end

	// read port; the mask bit is write-only and reads zero
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rd_data_o <= '0;
		end else if (ce_i) begin
			rd_data_o <= '0;
			if (rd_en_i) begin
				case (addr_i)
					ADDR_CONTROL: begin
						rd_data_o[CTL_WINDOW_BIT] <= ctrl.window_mode;
						rd_data_o[CTL_HALT_BIT] <= ctrl.halt_in_debug;
						rd_data_o[CTL_RATE_MSB:0] <= ctrl.timeout_rate;
					end
					ADDR_SERVICE: rd_data_o <= '0;
					ADDR_CLKSEL: rd_data_o[1:0] <= clksel;
					ADDR_STATUS: rd_data_o <= {5'h0, svc_state == SVC_ARMED, run, enabled};
					default: rd_data_o <= '0;
				endcase
			end
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	svc_reads_zero_a: assert property (
		rd_en_i && ce_i && addr_i == ADDR_SERVICE |=> rd_data_o == 8'h00)
		else $error("service register read non-zero");
	expiry_reset_a: assert property (
		expire |=> wd_reset_o && cnt == '0)
		else $error("expiry did not raise reset");
	bad_value_reset_a: assert property (
		bad_value |=> wd_reset_o)
		else $error("wrong service value did not reset");
	window_early_a: assert property (
		ce_i && svc_wr && enabled && window_eff && cnt < win_start |=> wd_reset_o)
		else $error("early window service did not reset");
	halt_sticky_a: assert property (
		ctl_wr && !special_mode_i && !load_pending && ctrl.halt_in_debug
		|=> ctrl.halt_in_debug)
		else $error("halt bit cleared in normal mode");
	masked_write_a: assert property (
		ctl_wr && wr_data_i[CTL_MASK_BIT] && !load_pending
		|=> $stable(ctrl.window_mode) && $stable(ctrl.timeout_rate) && $stable(once_used))
		else $error("masked write changed fields");
	write_once_a: assert property (
		ctl_wr && !special_mode_i && once_used && !load_pending
		|=> $stable(ctrl.timeout_rate) ##1 $stable(ctrl.timeout_rate))
		else $error("second normal write took effect");
	restart_clears_a: assert property (
		ctl_wr && special_mode_i && !load_pending |=> cnt == '0)
		else $error("special write did not restart");
	stop_freeze_a: assert property (
		ce_i && stop_mode_i && !clksel.wd_autonomous_select && !clksel.wd_osc_select
		&& !restart && enabled |=> $stable(cnt))
		else $error("counter moved in full stop");
	debug_freeze_a: assert property (
		ce_i && background_debug_i && ctrl.halt_in_debug && !restart
		|=> $stable(cnt) && periodic_tick_halt_o)
		else $error("counter moved in halted debug");
	debug_long_a: assert property (
		debug_long |-> eff_shift == DEBUG_LONG_SHIFT - 5'(RATE_SHIFT_REDUCE) && !window_eff)
		else $error("debug period not the longest");

	service_ok_c: cover property (svc_wr && enabled && svc_state == SVC_ARMED
		&& wr_data_i == SERVICE_SECOND && !early_write);
	window_service_c: cover property (service_done && window_eff);
	expiry_c: cover property (expire);
	osc_loss_c: cover property (ce_i && osc_ok_q && !osc_ok_flag_i && clksel.wd_osc_select);

endmodule

// File: bench/tb_top.sv
// self-checking bench for the watchdog control block, driven straight at its ports
// assumes RATE_SHIFT_REDUCE of 5, so rate 1 on the crystal or RC tick times out after 512 ticks
`timescale 1ns/1ns
module tb_top
	import wd_pkg::*;
;
	logic clk_i, sys_rst_i, ce_i, wr_en_i, rd_en_i, aclk_tick_i;
	logic [7:0] addr_i, wr_data_i, rd_data_o;
	logic stop_mode_i, pseudo_stop_select_i, osc_run_in_pseudo_stop_i, osc_ok_flag_i;
	logic special_mode_i, background_debug_i, wd_reset_o, periodic_tick_halt_o;
	wd_ctrl_t flash_ctrl_i;
	int n_fail, n_compared;

	wd_control #(.RATE_SHIFT_REDUCE(5)) i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.ce_i(ce_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_en_i(wr_en_i),
		.rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .aclk_tick_i(aclk_tick_i),
		.internal_rc_clock_i(1'b1), .crystal_clock_i(1'b1), .flash_ctrl_i(flash_ctrl_i),
		.special_mode_i(special_mode_i), .stop_mode_i(stop_mode_i),
		.pseudo_stop_select_i(pseudo_stop_select_i),
		.osc_run_in_pseudo_stop_i(osc_run_in_pseudo_stop_i), .osc_ok_flag_i(osc_ok_flag_i),
		.background_debug_i(background_debug_i), .wd_reset_o(wd_reset_o),
		.periodic_tick_halt_o(periodic_tick_halt_o));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// the autonomous tick runs at half the system rate
	always @(posedge clk_i) begin
		aclk_tick_i <= ~aclk_tick_i;
	end

	task automatic fail(input logic [31:0] got, input logic [31:0] exp);
		n_fail++;
		$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) fail({24'h00_0000, got}, {24'h00_0000, exp});
	endtask

	task automatic rst(input logic [4:0] f, input logic sp);
		@(posedge clk_i);
		sys_rst_i <= 1'b1;
		flash_ctrl_i <= f;
		special_mode_i <= sp;
		stop_mode_i <= 1'b0;
		pseudo_stop_select_i <= 1'b0;
		osc_run_in_pseudo_stop_i <= 1'b0;
		osc_ok_flag_i <= 1'b1;
		repeat (12) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_en_i <= 1'b1;
		addr_i <= a;
		wr_data_i <= d;
		@(posedge clk_i);
		wr_en_i <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe, so sample just after that edge
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		rd_en_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_en_i <= 1'b0;
		#1;
		chk(rd_data_o, exp);
	endtask

	task automatic quiet(input int n);
		logic bad;
		bad = 1'b0;
		// a pulse launched at the edge just before the call is seen here too
		#1;
		if (wd_reset_o !== 1'b0) bad = 1'b1;
		repeat (n) begin
			@(posedge clk_i);
			#1;
			if (wd_reset_o !== 1'b0) bad = 1'b1;
		end
		chk({7'h00, bad}, 8'h00);
	endtask

	task automatic wait_rst(input int lo, input int hi);
		int n;
		// the one-cycle pulse after a write stands before the next edge, so look first
		#1;
		for (n = 0; n < hi; n++) begin
			if (wd_reset_o === 1'b1) break;
			@(posedge clk_i);
			#1;
		end
		n_compared++;
		if (n < lo || n >= hi) fail(n, lo);
	endtask

	task automatic t_load_and_expire();
		rst(5'h01, 1'b0);
		rd(ADDR_CONTROL, 8'h01);
		rd(ADDR_SERVICE, 8'h00);
		rd(ADDR_CLKSEL, 8'h00);
		wr(8'h30, 8'hFF);
		rd(8'h30, 8'h00);
		wait_rst(480, 520);
	endtask

	task automatic t_service();
		rst(5'h01, 1'b0);
		repeat (4) begin
			quiet(300);
			wr(ADDR_SERVICE, SERVICE_FIRST);
			wr(ADDR_SERVICE, SERVICE_SECOND);
		end
		wr(ADDR_SERVICE, 8'h12);
		wait_rst(0, 3);
	endtask

	task automatic t_write_rules();
		rst(5'h01, 1'b0);
		wr(ADDR_CONTROL, 8'h83);
		rd(ADDR_CONTROL, 8'h83);
		wr(ADDR_CONTROL, 8'h04);
		rd(ADDR_CONTROL, 8'h83);
		rst(5'h01, 1'b0);
		wr(ADDR_CONTROL, 8'hA5);
		rd(ADDR_CONTROL, 8'h01);
		wr(ADDR_CONTROL, 8'h00);
		rd(ADDR_CONTROL, 8'h01);
		wr(ADDR_CONTROL, 8'h05);
		rd(ADDR_CONTROL, 8'h01);
		quiet(300);
		wr(ADDR_CONTROL, 8'h60);
		rd(ADDR_CONTROL, 8'h41);
		wr(ADDR_CONTROL, 8'h20);
		rd(ADDR_CONTROL, 8'h41);
		quiet(400);
		wait_rst(50, 160);
	endtask

	task automatic t_special();
		rst(5'h01, 1'b1);
		wr(ADDR_CONTROL, 8'h00);
		rd(ADDR_CONTROL, 8'h00);
		wr(ADDR_CONTROL, 8'h41);
		wr(ADDR_CONTROL, 8'h01);
		rd(ADDR_CONTROL, 8'h01);
		quiet(400);
		wr(ADDR_CONTROL, 8'h01);
		quiet(300);
		wait_rst(100, 260);
		wr(ADDR_CONTROL, 8'h00);
		wr(ADDR_SERVICE, 8'h12);
		quiet(20);
		rd(ADDR_SERVICE, 8'h00);
	endtask

	task automatic t_window();
		rst(5'h11, 1'b0);
		quiet(50);
		wr(ADDR_SERVICE, SERVICE_FIRST);
		wait_rst(0, 3);
		rst(5'h11, 1'b0);
		quiet(420);
		wr(ADDR_SERVICE, SERVICE_FIRST);
		wr(ADDR_SERVICE, SERVICE_FIRST);
		wr(ADDR_SERVICE, SERVICE_SECOND);
		quiet(10);
		wr(ADDR_SERVICE, SERVICE_FIRST);
		wait_rst(0, 3);
		// debug in special mode without the halt bit drops the window
		background_debug_i <= 1'b1;
		rst(5'h11, 1'b1);
		wr(ADDR_SERVICE, SERVICE_FIRST);
		quiet(20);
		background_debug_i <= 1'b0;
	endtask

	task automatic t_debug_halt();
		background_debug_i <= 1'b1;
		rst(5'h09, 1'b0);
		#1;
		chk({7'h00, periodic_tick_halt_o}, 8'h01);
		quiet(700);
		background_debug_i <= 1'b0;
		quiet(3);
		chk({7'h00, periodic_tick_halt_o}, 8'h00);
		wait_rst(400, 530);
	endtask

	task automatic t_clock_and_stop();
		rst(5'h01, 1'b0);
		quiet(400);
		wr(ADDR_CLKSEL, 8'h01);
		quiet(300);
		osc_ok_flag_i <= 1'b0;
		quiet(300);
		wait_rst(150, 260);
		rst(5'h01, 1'b0);
		stop_mode_i <= 1'b1;
		quiet(700);
		pseudo_stop_select_i <= 1'b1;
		osc_run_in_pseudo_stop_i <= 1'b1;
		wr(ADDR_CLKSEL, 8'h01);
		wait_rst(400, 530);
		wr(ADDR_CLKSEL, 8'h02);
		wait_rst(4, 40);
	endtask

	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		n_fail = 0;
		n_compared = 0;
		sys_rst_i = 1'b1;
		ce_i = 1'b1;
		wr_en_i = 1'b0;
		rd_en_i = 1'b0;
		addr_i = 8'h00;
		wr_data_i = 8'h00;
		aclk_tick_i = 1'b0;
		flash_ctrl_i = 5'h00;
		special_mode_i = 1'b0;
		stop_mode_i = 1'b0;
		pseudo_stop_select_i = 1'b0;
		osc_run_in_pseudo_stop_i = 1'b0;
		osc_ok_flag_i = 1'b1;
		background_debug_i = 1'b0;
		t_load_and_expire();
		t_service();
		t_write_rules();
		t_special();
		t_window();
		t_debug_halt();
		t_clock_and_stop();
		close_out();
	end

	// the scenarios need well under 15000 cycles; a hang is cut off far beyond that
	initial begin
		#320000;
		n_fail++;
		close_out();
	end
endmodule
